// ### rtl/srstc_top.sv
`timescale 1ns/100ps
`default_nettype none

module srstc_top (
	// Clock and reset
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	// Reset sources
	input  wire logic                          reset_pin_n,
	input  wire logic                          wdog_overflow,
	input  wire logic                          software_break_instr,
	input  wire logic [1:0]                    interrupt_level_field,
	// Reset outputs
	output logic                               power_rst,
	output logic                               sfr_rst,
	output logic                               cpu_rst,
	output logic [1:0]                         wdog_period_sel,
	// Program memory vector read
	output logic                               pm_rd,
	output logic [15:0]                        pm_addr,
	input  wire logic [7:0]                    pm_rdata,
	// CPU register load
	output logic                               vec_load,
	output logic [15:0]                        sp_value,
	output logic [15:0]                        pc_value,
	// Interrupt
	output logic                               irq,
	// AXI4-Lite write address and data
	input  wire logic [srstc_pkg::ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [srstc_pkg::DATA_W-1:0]  s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	// AXI4-Lite read
	input  wire logic [srstc_pkg::ADDR_W-1:0]  s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	output logic [srstc_pkg::DATA_W-1:0]       s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready
);
	import srstc_pkg::*;

	// ****************************************
	// Declarations
	// ****************************************
	logic               pin_n_s;                   // Synchronised pin
	logic               full_src;                  // Pin or watchdog request
	logic               any_src;                   // Any reset request
	srstc_state_t       st_q;                      // Sequencer state
	logic               full_q;                    // Current reset is a full one
	logic               alt_q;                     // Use alternate PC vector
	logic [2:0]         cnt_q;                     // Fetch step
	logic [7:0]         lo_q;                      // Low byte of the word in flight
	logic               wflag_q;                   // Watchdog reset flag
	logic [EV_N-1:0]    ev_st_q;                   // Sticky event status
	logic [EV_N-1:0]    ev_en_q;                   // Event enables
	logic [EV_N-1:0]    ev_set;                    // Events this cycle
	logic [ADDR_W-1:0]  awaddr_q;                  // Latched write address
	logic [7:0]         wdata_q;                   // Latched write data
	logic               wlane_q;                   // Latched lane 0 strobe
	logic               aw_have_q;                 // Write address held
	logic               w_have_q;                  // Write data held
	logic               wr_go;                     // Perform the write now
	logic [17:0]        wr_idx;                    // Index of the write
	logic [17:0]        rd_idx;                    // Index of the read

	// Byte address to register index, used by both channels
	function automatic logic [17:0] reg_idx(input logic [ADDR_W-1:0] a);
		reg_idx = a[ADDR_W-1:2];
	endfunction
	// Mapped register test
	function automatic logic is_mapped(input logic [17:0] i);
		is_mapped = (i == IDX_CAUSE) || (i == IDX_WDPER) || (i == IDX_IRQ_ST)
			|| (i == IDX_IRQ_CLR) || (i == IDX_IRQ_EN);
	endfunction

	// ****************************************
	// Pin synchroniser
	// ****************************************
	srstc_sync u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.pin_n   (reset_pin_n),
		.pin_n_s (pin_n_s)
	);
	assign full_src = !pin_n_s || wdog_overflow;
	assign any_src  = full_src || software_break_instr;
	assign ev_set   = {software_break_instr, wdog_overflow, !pin_n_s};

	// ****************************************
	// Reset sequencer
	// ****************************************
	// A new request restarts the sequence from any state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q   <= SRSTC_HOLD;
			full_q <= 1'b1;
			alt_q  <= 1'b0;
			cnt_q  <= 3'h0;
		end else if (any_src) begin
			st_q  <= SRSTC_HOLD;
			cnt_q <= 3'h0;
			// Full request outranks a break, even mid sequence
			if (full_src) begin
				full_q <= 1'b1;
				alt_q  <= 1'b0;
			end else if (st_q == SRSTC_IDLE || !full_q) begin
				full_q <= 1'b0;
				alt_q  <= (interrupt_level_field <= LOW_LEVEL_MAX);
			end
		end else begin
			case (st_q)
				// Source gone, start vector fetch
				SRSTC_HOLD: st_q <= SRSTC_FETCH;
				// Four byte fetch, last step hands over
				SRSTC_FETCH: begin
					if (cnt_q == FETCH_LAST) begin
						st_q <= SRSTC_IDLE;
					end else begin
						cnt_q <= cnt_q + 3'h1;
					end
				end
				// Running
				default: st_q <= SRSTC_IDLE;
			endcase
		end
	end

	// ****************************************
	// Reset outputs
	// ****************************************
	// CPU held on every reset kind, others only on full resets
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cpu_rst   <= 1'b1;
			sfr_rst   <= 1'b1;
			power_rst <= 1'b1;
		end else begin
			cpu_rst   <= any_src || st_q != SRSTC_IDLE;
			sfr_rst   <= full_src || (full_q && st_q == SRSTC_HOLD);
			power_rst <= full_src || (full_q && st_q == SRSTC_HOLD);
		end
	end

	// ****************************************
	// Vector fetch
	// ****************************************
	// Address shown in the step before its byte is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pm_rd   <= 1'b0;
			pm_addr <= VEC_SP;
		end else if (st_q == SRSTC_FETCH && !any_src && cnt_q != FETCH_LAST) begin
			pm_rd <= 1'b1;
			case (cnt_q)
				3'h0:    pm_addr <= VEC_SP;
				3'h1:    pm_addr <= VEC_SP + 16'h0001;
				3'h2:    pm_addr <= alt_q ? VEC_PC_ALT : VEC_PC;
				default: pm_addr <= (alt_q ? VEC_PC_ALT : VEC_PC) + 16'h0001;
			endcase
		end else begin
			pm_rd <= 1'b0;
		end
	end

	// Bytes taken low first, word completed on even steps
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lo_q     <= 8'h00;
			sp_value <= 16'h0000;
			pc_value <= 16'h0000;
			vec_load <= 1'b0;
		end else begin
			vec_load <= 1'b0;
			if (st_q == SRSTC_FETCH && !any_src && cnt_q != 3'h0) begin
				case (cnt_q)
					3'h2:    sp_value <= {pm_rdata, lo_q};
					3'h4:    pc_value <= {pm_rdata, lo_q};
					default: lo_q     <= pm_rdata;
				endcase
				vec_load <= (cnt_q == FETCH_LAST);
			end
		end
	end

	// ****************************************
	// Cause flag and watchdog period
	// ****************************************
	// Watchdog flag only; internal resets keep it, event beats software write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wflag_q <= 1'b0;
		end else if (wdog_overflow) begin
			wflag_q <= 1'b1;
		end else if (wr_go && wlane_q && wr_idx == IDX_CAUSE) begin
			wflag_q <= wdata_q[WDOG_FLAG_BIT];
		end
	end

	// Period select is an SFR, so full resets restore it
	always_ff @(posedge aclk) begin
		if (!aresetn || full_src) begin
			wdog_period_sel <= WDPER_RST;
		end else if (wr_go && wlane_q && wr_idx == IDX_WDPER) begin
			wdog_period_sel <= wdata_q[1:0];
		end
	end

	// ****************************************
	// Interrupt status, enable and output
	// ****************************************
	// Set wins over a clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ev_st_q <= EV_RST;
			ev_en_q <= EV_RST;
			irq     <= 1'b0;
		end else begin
			if (wr_go && wlane_q && wr_idx == IDX_IRQ_CLR) begin
				ev_st_q <= (ev_st_q & ~wdata_q[EV_N-1:0]) | ev_set;
			end else begin
				ev_st_q <= ev_st_q | ev_set;
			end
			if (wr_go && wlane_q && wr_idx == IDX_IRQ_EN) begin
				ev_en_q <= wdata_q[EV_N-1:0];
			end
			irq <= |(ev_st_q & ev_en_q);
		end
	end

	// ****************************************
	// AXI4-Lite write channels
	// ****************************************
	assign wr_go  = aw_have_q && w_have_q && !s_axi_bvalid;
	assign wr_idx = reg_idx(awaddr_q);
	// Address and data taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			awaddr_q      <= '0;
			wdata_q       <= 8'h00;
			wlane_q       <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_have_q && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				wdata_q  <= s_axi_wdata[7:0];
				wlane_q  <= s_axi_wstrb[0];
			end
			if (wr_go) begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= is_mapped(wr_idx) ? RESP_OKAY : RESP_SLV;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ****************************************
	// AXI4-Lite read channel
	// ****************************************
	assign rd_idx = reg_idx(s_axi_araddr);
	// Read data one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= is_mapped(rd_idx) ? RESP_OKAY : RESP_SLV;
				s_axi_rdata  <= '0;
				case (rd_idx)
					IDX_CAUSE:  s_axi_rdata[WDOG_FLAG_BIT] <= wflag_q;
					IDX_WDPER:  s_axi_rdata[1:0]           <= wdog_period_sel;
					IDX_IRQ_ST: s_axi_rdata[EV_N-1:0]      <= ev_st_q;
					IDX_IRQ_EN: s_axi_rdata[EV_N-1:0]      <= ev_en_q;
					default:    s_axi_rdata                <= '0;
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	a_src_cpu_rst: assert property (@(posedge aclk) disable iff (!aresetn)
		any_src |=> cpu_rst)
		else $error("reset request did not hold the CPU");
	a_pin_holds: assert property (@(posedge aclk) disable iff (!aresetn)
		(!reset_pin_n) [*3] |=> cpu_rst && power_rst)
		else $error("low pin did not hold reset");
	a_brk_keeps_sfr: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_q == SRSTC_IDLE && software_break_instr && !full_src) |=> !power_rst && !sfr_rst)
		else $error("break reset touched power or SFRs");
	a_full_resets: assert property (@(posedge aclk) disable iff (!aresetn)
		full_src |=> power_rst && sfr_rst && wdog_period_sel == WDPER_RST)
		else $error("full reset missed power or SFRs");
	a_wdog_flag: assert property (@(posedge aclk) disable iff (!aresetn)
		wdog_overflow |=> wflag_q)
		else $error("watchdog flag not set");
	a_flag_kept: assert property (@(posedge aclk) disable iff (!aresetn)
		(wflag_q && !(wr_go && wr_idx == IDX_CAUSE)) |=> wflag_q)
		else $error("cause flag lost without a write");
	a_cause_bits: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_arvalid && s_axi_arready && rd_idx == IDX_CAUSE)
		|=> s_axi_rdata[7:0] == {5'h00, $past(wflag_q), 2'h0})
		else $error("cause register shows an extra bit");
	a_sp_addr: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_q == SRSTC_FETCH && cnt_q == 3'h0 && !any_src) |=> pm_rd && pm_addr == VEC_SP)
		else $error("stack pointer vector address wrong");
	a_pc_addr: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_q == SRSTC_FETCH && cnt_q == 3'h2 && !any_src)
		|=> pm_addr == ($past(alt_q) ? VEC_PC_ALT : VEC_PC))
		else $error("program counter vector address wrong");
	a_release_load: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(cpu_rst) |-> $past(vec_load) || vec_load)
		else $error("CPU released without vectors");

endmodule

`default_nettype wire

// ### rtl/srstc_pkg.sv
package srstc_pkg;

	// ****************************************
	// Register bus geometry
	// ****************************************
	localparam int unsigned ADDR_W    = 20;                 // AXI byte address width
	localparam int unsigned DATA_W    = 32;                 // AXI data width
	localparam int unsigned REG_W     = 8;                  // Width of every register
	localparam logic [1:0]  RESP_OKAY = 2'h0;               // Normal answer
	localparam logic [1:0]  RESP_SLV  = 2'h2;               // Unmapped address answer

	// ****************************************
	// Register indices, byte address is index times four
	// ****************************************
	localparam logic [17:0] IDX_CAUSE   = 18'h0_F001;       // reset_cause_status
	localparam logic [17:0] IDX_WDPER   = 18'h0_F002;       // Watchdog period select
	localparam logic [17:0] IDX_IRQ_ST  = 18'h0_F003;       // Interrupt status, read only
	localparam logic [17:0] IDX_IRQ_CLR = 18'h0_F004;       // Interrupt clear, write only
	localparam logic [17:0] IDX_IRQ_EN  = 18'h0_F005;       // Interrupt enable

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int unsigned  WDOG_FLAG_BIT = 2;             // wdog_reset_flag position
	localparam int unsigned  EV_PIN        = 0;             // Event bit, pin reset
	localparam int unsigned  EV_WDOG       = 1;             // Event bit, watchdog reset
	localparam int unsigned  EV_BRK        = 2;             // Event bit, break reset
	localparam int unsigned  EV_N          = 3;             // Number of events
	localparam logic [1:0]   WDPER_RST     = 2'h0;          // Period select after reset
	localparam logic [2:0]   EV_RST        = 3'h0;          // Event registers after reset
	localparam logic [1:0]   LOW_LEVEL_MAX = 2'h1;          // Highest level using alt vector

	// ****************************************
	// Watchdog overflow periods in ms, by select code
	// ****************************************
	localparam int unsigned WDPER_MS_0 = 125;
	localparam int unsigned WDPER_MS_1 = 500;
	localparam int unsigned WDPER_MS_2 = 2000;
	localparam int unsigned WDPER_MS_3 = 8000;

	// ****************************************
	// Program memory vector addresses
	// ****************************************
	localparam logic [15:0] VEC_SP     = 16'h0000;          // Stack pointer word
	localparam logic [15:0] VEC_PC     = 16'h0002;          // Normal program counter word
	localparam logic [15:0] VEC_PC_ALT = 16'h0004;          // Break at low level
	localparam logic [2:0]  FETCH_LAST = 3'h4;              // Step that takes the last byte

	// Sequencer states
	typedef enum logic [1:0] {
		SRSTC_IDLE,
		SRSTC_HOLD,
		SRSTC_FETCH
	} srstc_state_t;

endpackage

// ### rtl/srstc_sync.sv
`timescale 1ns/100ps
`default_nettype none

// Two stage synchroniser for the external reset pin
module srstc_sync (
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Pin and result
	input  wire logic pin_n,
	output logic      pin_n_s
);

	logic meta_q;                                       // First stage, read only by second

	// ****************************************
	// Synchroniser chain, idles at released level
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_q  <= 1'b1;
			pin_n_s <= 1'b1;
		end else begin
			meta_q  <= pin_n;
			pin_n_s <= meta_q;
		end
	end

endmodule

`default_nettype wire

// ### verif/srstc_pmem_model.sv
`timescale 1ns/100ps
`default_nettype none

// Asynchronous program memory holding the reset vectors
module srstc_pmem_model (
	// Read port
	input  wire logic        pm_rd,
	input  wire logic [15:0] pm_addr,
	output logic      [7:0]  pm_rdata
);
	logic [7:0] last_byte; // Last byte driven while selected

	// ****************************************
	// Vector table, low byte at the lower address
	// ****************************************
	function automatic logic [7:0] rom_byte(input logic [15:0] a);
		case (a)
			16'h0000: rom_byte = 8'h34;     // Stack pointer low
			16'h0001: rom_byte = 8'h12;     // Stack pointer high
			16'h0002: rom_byte = 8'h78;     // Normal entry low
			16'h0003: rom_byte = 8'h56;     // Normal entry high
			16'h0004: rom_byte = 8'hBC;     // Alternate entry low
			16'h0005: rom_byte = 8'h9A;     // Alternate entry high
			default:  rom_byte = a[7:0] ^ 8'hA5;
		endcase
	endfunction

	// Deselected bus shows the inverse of the last byte, never a stale value
	always @(pm_rd or pm_addr) begin
		if (pm_rd) begin
			last_byte = rom_byte(pm_addr);
			pm_rdata  = last_byte;
		end else begin
			pm_rdata = ~last_byte;
		end
	end
endmodule

`default_nettype wire

// ### verif/tb_system_reset_controller.sv
`timescale 1ns/100ps
`default_nettype none

module tb_system_reset_controller;
	import srstc_pkg::*;

	// ****************************************
	// Signals
	// ****************************************
	logic                aclk, aresetn, reset_pin_n, wdog_overflow, software_break_instr;
	logic                power_rst, sfr_rst, cpu_rst, pm_rd, vec_load, irq;
	logic [1:0]          interrupt_level_field, wdog_period_sel, s_axi_bresp, s_axi_rresp;
	logic [7:0]          pm_rdata;
	logic [15:0]         pm_addr, sp_value, pc_value;
	logic [ADDR_W-1:0]   s_axi_awaddr, s_axi_araddr;
	logic [DATA_W-1:0]   s_axi_wdata, s_axi_rdata;
	logic [3:0]          s_axi_wstrb;
	logic                s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic                s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	int                  n_mismatch = 0;      // Failed comparisons
	int                  samples_checked = 0; // All comparisons

	srstc_top dut_u (
		.aclk(aclk), .aresetn(aresetn), .reset_pin_n(reset_pin_n), .wdog_overflow(wdog_overflow),
		.software_break_instr(software_break_instr), .interrupt_level_field(interrupt_level_field),
		.power_rst(power_rst), .sfr_rst(sfr_rst), .cpu_rst(cpu_rst), .wdog_period_sel(wdog_period_sel),
		.pm_rd(pm_rd), .pm_addr(pm_addr), .pm_rdata(pm_rdata), .vec_load(vec_load),
		.sp_value(sp_value), .pc_value(pc_value), .irq(irq),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
	);

	srstc_pmem_model pmem_u (.pm_rd(pm_rd), .pm_addr(pm_addr), .pm_rdata(pm_rdata));

	// 100 MHz clock
	always #5 aclk = ~aclk;

	// ****************************************
	// Checking and reporting
	// ****************************************
	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task test_end(input string name);
		$display("Test %s done, mismatches so far %0d", name, n_mismatch);
	endtask

	task finish_test;
		$display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// ****************************************
	// Register bus master
	// ****************************************
	task axi_wr(input logic [17:0] idx, input logic [7:0] d, input logic [1:0] er);
		logic a_ok;
		logic w_ok;
		logic b_ok;
		a_ok = 1'b0;
		w_ok = 1'b0;
		b_ok = 1'b0;
		@(posedge aclk);
		s_axi_awaddr  <= {idx, 2'b00};
		s_axi_wdata   <= 32'(d);
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		while (!b_ok) begin
			@(posedge aclk);
			// Release each channel at its own handshake
			if (!a_ok && s_axi_awready === 1'b1) begin
				a_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_ok && s_axi_wready === 1'b1) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
			if (s_axi_bvalid === 1'b1) begin
				b_ok = 1'b1;
				s_axi_bready <= 1'b0;
				chk(32'(s_axi_bresp), 32'(er), "write response");
			end
		end
	endtask

	task rd_chk(input logic [17:0] idx, input logic [31:0] exp, input logic [1:0] er);
		logic r_ok;
		r_ok = 1'b0;
		@(posedge aclk);
		s_axi_araddr  <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		while (!r_ok) begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) begin
				r_ok = 1'b1;
				s_axi_rready <= 1'b0;
				chk(s_axi_rdata, exp, "read data");
				chk(32'(s_axi_rresp), 32'(er), "read response");
			end
		end
	endtask

	// ****************************************
	// Reset sources and vector fetch
	// ****************************************
	task brk_pulse(input logic [1:0] lvl);
		@(posedge aclk);
		software_break_instr  <= 1'b1;
		interrupt_level_field <= lvl;
		@(posedge aclk);
		software_break_instr <= 1'b0;
	endtask

	// Bounded wait for the vector load, then the CPU release
	task wait_load(input logic [15:0] esp, input logic [15:0] epc);
		int n;
		n = 0;
		while (vec_load !== 1'b1 && n < 100) begin
			@(negedge aclk);
			n++;
		end
		chk(32'(n < 100), 32'h1, "vector load seen");
		chk(32'(sp_value), 32'(esp), "stack pointer");
		chk(32'(pc_value), 32'(epc), "program counter");
		@(negedge aclk);
		chk(32'(cpu_rst), 32'h0, "cpu released");
	endtask

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		reset_pin_n = 1'b1;
		wdog_overflow = 1'b0;
		software_break_instr = 1'b0;
		interrupt_level_field = 2'h3;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'hF;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		wait_load(16'h1234, 16'h5678);
		test_end("power up");
		// Every period code, on the bus and on the port
		for (int i = 0; i < 4; i++) begin
			axi_wr(IDX_WDPER, 8'(i), RESP_OKAY);
			rd_chk(IDX_WDPER, 32'(i), RESP_OKAY);
			chk(32'(wdog_period_sel), 32'(i), "period select port");
		end
		axi_wr(IDX_CAUSE, 8'h00, RESP_OKAY);
		axi_wr(IDX_IRQ_CLR, 8'h07, RESP_OKAY);
		test_end("period select");
		// Break at every level: CPU only, vector by level
		for (int l = 0; l < 4; l++) begin
			brk_pulse(2'(l));
			@(negedge aclk);
			chk(32'({power_rst, sfr_rst, cpu_rst}), 32'h1, "break reset outputs");
			wait_load(16'h1234, (2'(l) <= LOW_LEVEL_MAX) ? 16'h9ABC : 16'h5678);
		end
		rd_chk(IDX_WDPER, 32'h3, RESP_OKAY);
		rd_chk(IDX_CAUSE, 32'h0, RESP_OKAY);
		rd_chk(IDX_IRQ_ST, 32'h4, RESP_OKAY);
		test_end("break");
		// Watchdog overtakes a break sequence in mid-fetch
		axi_wr(IDX_IRQ_CLR, 8'h07, RESP_OKAY);
		brk_pulse(2'h0);
		repeat (3) @(posedge aclk);
		wdog_overflow <= 1'b1;
		@(posedge aclk);
		wdog_overflow <= 1'b0;
		@(negedge aclk);
		chk(32'({power_rst, sfr_rst, cpu_rst}), 32'h7, "watchdog reset outputs");
		wait_load(16'h1234, 16'h5678);
		rd_chk(IDX_CAUSE, 32'h4, RESP_OKAY);
		rd_chk(IDX_WDPER, 32'(WDPER_RST), RESP_OKAY);
		rd_chk(IDX_IRQ_ST, 32'h6, RESP_OKAY);
		test_end("watchdog");
		// Interrupt raised, masked, cleared
		axi_wr(IDX_IRQ_EN, 8'h02, RESP_OKAY);
		repeat (2) @(negedge aclk);
		chk(32'(irq), 32'h1, "irq enabled");
		axi_wr(IDX_IRQ_EN, 8'h00, RESP_OKAY);
		repeat (2) @(negedge aclk);
		chk(32'(irq), 32'h0, "irq masked");
		axi_wr(IDX_IRQ_EN, 8'h02, RESP_OKAY);
		axi_wr(IDX_IRQ_CLR, 8'h02, RESP_OKAY);
		repeat (2) @(negedge aclk);
		chk(32'(irq), 32'h0, "irq cleared");
		rd_chk(IDX_IRQ_ST, 32'h4, RESP_OKAY);
		axi_wr(IDX_IRQ_EN, 8'h00, RESP_OKAY);
		test_end("interrupt");
		// Pin held low keeps everything in reset
		@(posedge aclk);
		reset_pin_n <= 1'b0;
		repeat (20) @(negedge aclk);
		chk(32'({power_rst, sfr_rst, cpu_rst, vec_load}), 32'hE, "pin reset held");
		@(posedge aclk);
		reset_pin_n <= 1'b1;
		wait_load(16'h1234, 16'h5678);
		rd_chk(IDX_IRQ_ST, 32'h5, RESP_OKAY);
		rd_chk(IDX_CAUSE, 32'h4, RESP_OKAY);
		axi_wr(IDX_CAUSE, 8'h00, RESP_OKAY);
		rd_chk(IDX_CAUSE, 32'h0, RESP_OKAY);
		axi_wr(IDX_CAUSE, 8'h04, RESP_OKAY);
		rd_chk(IDX_CAUSE, 32'h4, RESP_OKAY);
		test_end("pin");
		// Unmapped place answers with an error
		rd_chk(18'h0_F0FF, 32'h0, RESP_SLV);
		axi_wr(18'h0_F0FF, 8'h55, RESP_SLV);
		test_end("unmapped");
		finish_test;
	end

	// Hang guard at 10,000 cycles, far beyond the few hundred cycles needed
	initial begin
		#100_000;
		n_mismatch++;
		$display("ERROR %0t: watchdog expired", $time);
		finish_test;
	end
endmodule

`default_nettype wire
